// file: src/ric_consts.vh
/*
 restart interlock control: register offsets, field positions, reset values
 and timing figures used by the design; the bench uses its own literals.
 assumes a 100 MHz mclk and a 32-bit plain register port.
*/
`ifndef RIC_CONSTS_VH
`define RIC_CONSTS_VH

// clock and time base
`define RIC_CLK_PERIOD_NS   32'h0000000A
`define RIC_TICK_NS         32'h000F4240
`define RIC_TICK_CYCLES     (`RIC_TICK_NS / `RIC_CLK_PERIOD_NS)

// reset-button window and stuck detection, in ms
`define RIC_PRESS_MIN_MS    16'h0096
`define RIC_PRESS_MAX_MS    16'h0FA0
`define RIC_PRESS_STUCK_MS  16'h7530

// start-up, contactor and blink timing, in ms
`define RIC_SELFTEST_MS     16'h01F4
`define RIC_SHOW_RT_MS      16'h07D0
`define RIC_EDM_MS          16'h012C
`define RIC_BLINK_MS        16'h00FA
`define RIC_RESP_TIME_MS    8'h0F

// register offsets (byte addresses)
`define RIC_REG_CTRL        8'h00
`define RIC_REG_STATUS      8'h04
`define RIC_REG_IRQ_STAT    8'h08
`define RIC_REG_IRQ_MASK    8'h0C
`define RIC_REG_PRESS       8'h10

// control register fields
`define RIC_CTRL_ALIGN      0

// status register fields
`define RIC_ST_STATE_LO     0
`define RIC_ST_STATE_HI     2
`define RIC_ST_RES_EN       4
`define RIC_ST_EDM_EN       5
`define RIC_ST_CHAN_TWO     6
`define RIC_ST_STD_POWER    7
`define RIC_ST_OSSD         8

// interrupt events
`define RIC_EV_ON           0
`define RIC_EV_OFF          1
`define RIC_EV_IGNORED      2
`define RIC_EV_STUCK        3
`define RIC_EV_EDM          4
`define RIC_EV_W            5

// reset values
`define RIC_CTRL_RST        1'b0
`define RIC_MASK_RST        5'h00

`endif

// file: src/ric_top.v
/*
 restart interlock control of a light-curtain receiver/transmitter:
 channel and range select, contactor feedback, restart interlock, reset
 button timing, status pin, indicators, start-up sequence and a small
 register file with a level interrupt.
 assumes one 100 MHz clock, connector pins arriving asynchronously, and
 optics flags (beam clear, marginal, fault) coming from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ric_consts.vh"

module ric_top
#(
   parameter integer TICK_CYCLES = `RIC_TICK_CYCLES
)
(
   input  wire        mclk,
   input  wire        reset_n,
   // connector pins
   input  wire        supply_pin_a,
   input  wire        supply_pin_b,
   input  wire        range_select,
   input  wire        feedback_monitor_input,
   input  wire        feedback_monitor_open,
   input  wire        interlock_select_input,
   input  wire        reset_status_pin_in,
   output reg         reset_status_pin_out,
   output reg         reset_status_pin_oe,
   output reg         safety_output_a,
   output reg         safety_output_b,
   // optics flags from the receive logic
   input  wire        beam_clear,
   input  wire        beam_marginal,
   input  wire        optics_fault,
   // optics control
   output reg         optical_channel_two,
   output reg         tx_power_standard,
   // indicators
   output reg         led_green,
   output reg         led_red,
   output reg         led_yellow,
   output reg  [1:0]  display_mode,
   output reg  [7:0]  display_value,
   output reg         display_flash,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   output reg         irq
);
   // states
   localparam [2:0] ST_SELF  = 3'h0;
   localparam [2:0] ST_SHOW  = 3'h1;
   localparam [2:0] ST_LOCK  = 3'h2;
   localparam [2:0] ST_ON    = 3'h3;
   localparam [2:0] ST_FAULT = 3'h4;
   // display modes
   localparam [1:0] DM_TEST  = 2'h0;
   localparam [1:0] DM_RESP  = 2'h1;
   localparam [1:0] DM_RUN   = 2'h2;
   localparam [1:0] DM_ALIGN = 2'h3;
   localparam [16:0] TICK_LAST  = TICK_CYCLES[16:0] - 17'h00001;
   localparam [15:0] P_MIN      = `RIC_PRESS_MIN_MS;
   localparam [15:0] P_MAX      = `RIC_PRESS_MAX_MS;
   localparam [15:0] P_STUCK    = `RIC_PRESS_STUCK_MS;
   localparam [15:0] T_SELF     = `RIC_SELFTEST_MS;
   localparam [15:0] T_SHOW     = `RIC_SHOW_RT_MS;
   localparam [15:0] T_EDM      = `RIC_EDM_MS;
   localparam [15:0] T_BLINK    = `RIC_BLINK_MS;
   localparam integer NPIN      = 7;
   wire [NPIN-1:0] pin_raw;
   reg  [NPIN-1:0] sync1_ff;
   reg  [NPIN-1:0] sync2_ff;
   genvar          gi;
   reg  [16:0] tick_cnt_ff;
   reg         tick_ff;
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [15:0] timer_ff;
   reg  [15:0] nxt_timer;
   reg  [15:0] press_ff;
   reg  [15:0] nxt_press;
   reg  [15:0] last_press_ff;
   reg  [15:0] nxt_last_press;
   reg         pressed_ff;
   reg         ignored_ff;
   reg         nxt_ignored;
   reg         res_en_ff;
   reg         nxt_res_en;
   reg  [15:0] blink_cnt_ff;
   reg         blink_ff;
   reg  [1:0]  oe_hist_ff;
   reg         align_ff;
   reg  [4:0]  irq_stat_ff;
   reg  [4:0]  irq_mask_ff;
   reg  [4:0]  ev;
   reg  [4:0]  nxt_stat;
   reg         nxt_ossd;
   reg         nxt_status;
   wire s_sup_a   = sync2_ff[0];
   wire s_sup_b   = sync2_ff[1];
   wire s_range   = sync2_ff[2];
   wire s_fb_hi   = sync2_ff[3];
   wire s_fb_open = sync2_ff[4];
   wire s_ilk     = sync2_ff[5];
   wire s_rst_pin = sync2_ff[6];
   // feedback pin decode: high disables, low closed loop, open loop
   wire edm_en      = ~s_fb_hi;
   wire loop_closed = ~s_fb_hi & ~s_fb_open;
   // the pin is only a button while nothing of ours drives it
   wire btn         = s_rst_pin & ~reset_status_pin_oe & ~(|oe_hist_ff);
   wire field_ok    = beam_clear & ~optics_fault;
   wire edm_ok      = ~edm_en | loop_closed;
   wire wr_ctrl     = reg_wr & (reg_addr == `RIC_REG_CTRL);
   wire wr_stat     = reg_wr & (reg_addr == `RIC_REG_IRQ_STAT);
   wire wr_mask     = reg_wr & (reg_addr == `RIC_REG_IRQ_MASK);
   assign pin_raw = {reset_status_pin_in, interlock_select_input,
                     feedback_monitor_open, feedback_monitor_input,
                     range_select, supply_pin_b, supply_pin_a};
   // two-stage synchroniser on every connector input
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1)
      begin : g_sync
         always @(posedge mclk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end
            else
            begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate
   // millisecond enable and blink phase
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tick_cnt_ff  <= 17'h00000;
         tick_ff      <= 1'b0;
         blink_cnt_ff <= 16'h0000;
         blink_ff     <= 1'b0;
      end
      else
      begin
         tick_ff <= (tick_cnt_ff == TICK_LAST);
         if (tick_cnt_ff == TICK_LAST)
            tick_cnt_ff <= 17'h00000;
         else
            tick_cnt_ff <= tick_cnt_ff + 17'h00001;
         if (tick_ff)
         begin
            if (blink_cnt_ff == T_BLINK - 16'h0001)
            begin
               blink_cnt_ff <= 16'h0000;
               blink_ff     <= ~blink_ff;
            end
            else
               blink_cnt_ff <= blink_cnt_ff + 16'h0001;
         end
      end
   end

   // sequencer: start-up, lock, on and fault interlock
   always @*
   begin
      nxt_state      = state_ff;
      nxt_timer      = timer_ff;
      nxt_press      = press_ff;
      nxt_last_press = last_press_ff;
      nxt_ignored    = ignored_ff;
      nxt_res_en     = res_en_ff;
      ev             = 5'h00;
      if (tick_ff && timer_ff != 16'hFFFF)
         nxt_timer = timer_ff + 16'h0001;
      // count the press length in ms, saturating at the stuck limit
      if (btn && !pressed_ff)
      begin
         nxt_press   = 16'h0000;
         nxt_ignored = 1'b0;
      end
      else if (btn && tick_ff && press_ff != P_STUCK)
         nxt_press = press_ff + 16'h0001;
      case (state_ff)
         ST_SELF:
         begin
            // status pin is undriven here, so a bridged select reads low
            nxt_res_en = s_ilk;
            if (timer_ff >= T_SELF)
            begin
               nxt_state = ST_SHOW;
               nxt_timer = 16'h0000;
            end
         end
         ST_SHOW:
            if (timer_ff >= T_SHOW)
            begin
               nxt_state = ST_LOCK;
               nxt_timer = 16'h0000;
            end
         ST_LOCK:
         begin
            if (btn && press_ff == P_STUCK)
            begin
               nxt_state = ST_FAULT;
               ev[`RIC_EV_STUCK] = 1'b1;
            end
            else if (btn && press_ff >= P_MAX && !ignored_ff)
            begin
               nxt_ignored = 1'b1;
               ev[`RIC_EV_IGNORED] = 1'b1;
            end
            else if (!res_en_ff)
            begin
               if (field_ok && edm_ok)
                  nxt_state = ST_ON;
            end
            else if (!btn && pressed_ff)
            begin
               nxt_last_press = press_ff;
               // too short or too long leaves the lock engaged
               if (press_ff >= P_MIN && press_ff < P_MAX && !ignored_ff
                   && field_ok && edm_ok)
                  nxt_state = ST_ON;
            end
            if (nxt_state == ST_ON)
            begin
               nxt_timer = 16'h0000;
               ev[`RIC_EV_ON] = 1'b1;
            end
         end
         ST_ON:
            if (!field_ok)
            begin
               nxt_state = ST_LOCK;
               ev[`RIC_EV_OFF] = 1'b1;
            end
            else if (edm_en && loop_closed && timer_ff >= T_EDM)
            begin
               // contactor never dropped its feedback contact
               nxt_state = ST_FAULT;
               ev[`RIC_EV_EDM] = 1'b1;
               ev[`RIC_EV_OFF] = 1'b1;
            end
            else if (!edm_en || !loop_closed)
               nxt_timer = 16'h0000;
         ST_FAULT:
            nxt_state = ST_FAULT;
         default:
            nxt_state = ST_FAULT;
      endcase
      nxt_ossd   = (nxt_state == ST_ON);
      nxt_status = nxt_ossd & ~beam_marginal;
      // hardware set wins over a write-one clear in the same cycle
      nxt_stat = irq_stat_ff;
      if (wr_stat)
         nxt_stat = irq_stat_ff & ~reg_wdata[4:0];
      nxt_stat = nxt_stat | ev;
   end

   // control state registers
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff      <= ST_SELF;
         timer_ff      <= 16'h0000;
         press_ff      <= 16'h0000;
         last_press_ff <= 16'h0000;
         pressed_ff    <= 1'b0;
         ignored_ff    <= 1'b0;
         res_en_ff     <= 1'b1;
         oe_hist_ff    <= 2'h0;
         align_ff      <= `RIC_CTRL_RST;
         irq_stat_ff   <= 5'h00;
         irq_mask_ff   <= `RIC_MASK_RST;
      end
      else
      begin
         state_ff      <= nxt_state;
         timer_ff      <= nxt_timer;
         press_ff      <= nxt_press;
         last_press_ff <= nxt_last_press;
         pressed_ff    <= btn;
         ignored_ff    <= nxt_ignored;
         res_en_ff     <= nxt_res_en;
         oe_hist_ff    <= {oe_hist_ff[0], reset_status_pin_oe};
         irq_stat_ff   <= nxt_stat;
         if (wr_ctrl)
            align_ff <= reg_wdata[`RIC_CTRL_ALIGN];
         if (wr_mask)
            irq_mask_ff <= reg_wdata[4:0];
      end
   end

   // registered pin, indicator and display outputs
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         safety_output_a      <= 1'b0;
         safety_output_b      <= 1'b0;
         reset_status_pin_out <= 1'b0;
         reset_status_pin_oe  <= 1'b0;
         optical_channel_two  <= 1'b0;
         tx_power_standard    <= 1'b0;
         led_green            <= 1'b0;
         led_red              <= 1'b0;
         led_yellow           <= 1'b0;
         display_mode         <= DM_TEST;
         display_value        <= 8'h00;
         display_flash        <= 1'b0;
         irq                  <= 1'b0;
      end
      else
      begin
         // both outputs from one term so they cannot part
         safety_output_a      <= nxt_ossd;
         safety_output_b      <= nxt_ossd;
         // drive high only; low is left to the pull-down so the button reads
         reset_status_pin_out <= nxt_status;
         reset_status_pin_oe  <= nxt_status;
         optical_channel_two  <= s_sup_b & ~s_sup_a;
         tx_power_standard    <= s_range;
         led_green            <= nxt_ossd & (~(align_ff & beam_marginal) | blink_ff);
         led_red              <= (nxt_state == ST_LOCK) | (nxt_state == ST_FAULT);
         led_yellow           <= (nxt_state == ST_LOCK) & res_en_ff & field_ok;
         if (nxt_state == ST_SELF)
            display_mode <= DM_TEST;
         else if (nxt_state == ST_SHOW)
            display_mode <= DM_RESP;
         else if (align_ff)
            display_mode <= DM_ALIGN;
         else
            display_mode <= DM_RUN;
         display_value        <= (nxt_state == ST_SHOW) ? `RIC_RESP_TIME_MS : {5'h00, nxt_state};
         display_flash        <= align_ff & blink_ff & (nxt_ossd | nxt_state == ST_LOCK);
         irq                  <= |(nxt_stat & irq_mask_ff);
      end
   end

   // register read port, data in the cycle after the strobe
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `RIC_REG_CTRL:
               reg_rdata <= {31'h00000000, align_ff};
            `RIC_REG_STATUS:
               reg_rdata <= {23'h000000, safety_output_a, tx_power_standard,
                             optical_channel_two, edm_en, res_en_ff, 1'b0, state_ff};
            `RIC_REG_IRQ_STAT:
               reg_rdata <= {27'h0000000, irq_stat_ff};
            `RIC_REG_IRQ_MASK:
               reg_rdata <= {27'h0000000, irq_mask_ff};
            `RIC_REG_PRESS:
               reg_rdata <= {16'h0000, last_press_ff};
            default:
               reg_rdata <= 32'h00000000;
         endcase
      end
      else
         reg_rdata <= 32'h00000000;
   end

endmodule
`default_nettype wire

// file: dv/ric_checker_assertions.sv
/*
 checker of the interlock control, watching only the top ports.
 assumes one clock mclk and the async active-low reset_n.
*/
`timescale 1ns/1ps
`default_nettype none
module ric_checker
(
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       supply_pin_a,
   input wire logic       supply_pin_b,
   input wire logic       range_select,
   input wire logic       beam_clear,
   input wire logic       optics_fault,
   input wire logic       reset_status_pin_oe,
   input wire logic       reset_status_pin_out,
   input wire logic       safety_output_a,
   input wire logic       safety_output_b,
   input wire logic       optical_channel_two,
   input wire logic       tx_power_standard,
   input wire logic       led_red,
   input wire logic [1:0] display_mode,
   input wire logic [7:0] display_value,
   input wire logic       display_flash
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // start-up steps: self test, then response time, then run
   sequence s_test_done;
      display_mode == 2'h0 ##1 display_mode != 2'h0;
   endsequence
   sequence s_show_done;
      display_mode == 2'h1 ##1 display_mode != 2'h1;
   endsequence
   property p_order;
      s_test_done |-> display_mode == 2'h1 && display_value == 8'h0F;
   endproperty
   a_order: assert property (p_order) else $error("self test not followed by time");
   property p_show;
      s_show_done |-> display_mode == 2'h2;
   endproperty
   a_show: assert property (p_show) else $error("time not followed by run");

   // pin selections settle once the pins are steady
   property p_chan;
      ($stable(supply_pin_a) && $stable(supply_pin_b))[*6]
         |-> optical_channel_two == (supply_pin_b && !supply_pin_a);
   endproperty
   a_chan: assert property (p_chan) else $error("channel select wrong");
   property p_power;
      $stable(range_select)[*6] |-> tx_power_standard == range_select;
   endproperty
   a_power: assert property (p_power) else $error("power select wrong");

   // safety outputs, status pin, red lamp and segment flash
   property p_pair;
      safety_output_a == safety_output_b;
   endproperty
   a_pair: assert property (p_pair) else $error("safety outputs differ");
   property p_status;
      reset_status_pin_oe |-> reset_status_pin_out && safety_output_a;
   endproperty
   a_status: assert property (p_status) else $error("status pin high with outputs off");
   property p_red;
      led_red |-> !safety_output_a;
   endproperty
   a_red: assert property (p_red) else $error("red lamp with outputs on");
   property p_drop;
      safety_output_a && (!beam_clear || optics_fault) |=> !safety_output_a;
   endproperty
   a_drop: assert property (p_drop) else $error("outputs stayed on after cut");
   property p_on;
      $rose(safety_output_a) |-> $past(beam_clear) && !$past(optics_fault);
   endproperty
   a_on: assert property (p_on) else $error("outputs on without clear field");
   property p_flash;
      display_mode != 2'h3 |-> !display_flash;
   endproperty
   a_flash: assert property (p_flash) else $error("segments flash outside alignment");
endmodule

bind ric_top ric_checker u_ric_checker (.*);
`default_nettype wire

// file: dv/ric_far_side.sv
/*
 far side of the interlock control: reset push-button, select bridge
 and contactor loop. assumes a pull-down on the status pin.
*/
`timescale 1ns/1ps
`default_nettype none
module ric_far_side
(
   input  wire logic mclk,
   input  wire logic reset_status_pin_out,
   input  wire logic reset_status_pin_oe,
   input  wire logic safety_output_a,
   input  wire logic bridge,
   input  wire logic select_high,
   input  wire logic mon_off,
   output wire logic reset_status_pin_in,
   output wire logic interlock_select_input,
   output wire logic feedback_monitor_input,
   output wire logic feedback_monitor_open
);
   logic pressed   = 1'b0;
   logic loop_open = 1'b0;
   // wire level: button or device pull high, pull-down otherwise
   assign reset_status_pin_in = pressed | (reset_status_pin_oe & reset_status_pin_out);
   // select pin held high or bridged onto the status pin
   assign interlock_select_input = bridge ? reset_status_pin_in : select_high;
   // contactor opens its loop one cycle after the outputs pull in
   always @(posedge mclk)
      loop_open <= safety_output_a;
   assign feedback_monitor_input = mon_off;
   assign feedback_monitor_open  = !mon_off && loop_open;
   // hold the button for n cycles, changed just after an edge
   task automatic push(input int n);
      @(posedge mclk);
      pressed <= 1'b1;
      repeat (n) @(posedge mclk);
      pressed <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/tb_restart_interlock_control.sv
/*
 bench of the interlock control: register port tasks and scenarios.
 assumes a short tick of TK cycles so every ms figure counts ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_restart_interlock_control;
   localparam integer TK = 2;
   logic        mclk, reset_n, supply_pin_a, supply_pin_b, range_select;
   logic        beam_clear, beam_marginal, optics_fault, reg_wr, reg_rd;
   logic        bridge, select_high, mon_off, f;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, d;
   int          fail_count, samples_checked, cyc;
   wire         reset_status_pin_in, interlock_select_input, feedback_monitor_input;
   wire         feedback_monitor_open, reset_status_pin_out, reset_status_pin_oe;
   wire         safety_output_a, safety_output_b, optical_channel_two, tx_power_standard;
   wire         led_green, led_red, led_yellow, display_flash, irq;
   wire [1:0]   display_mode;
   wire [7:0]   display_value;
   wire [31:0]  reg_rdata;

   ric_top #(.TICK_CYCLES(TK)) u_ric_top (.*);
   ric_far_side u_ric_far_side (.*);

   // compare helpers, one per kind of result
   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // register port: one-cycle strobes, read data in the following cycle
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
      rd_reg(a);
      chk_word(n, e, d);
   endtask
   // poll the state field, bounded at 30000 reads
   task automatic wait_st(input logic [2:0] s);
      int i;
      d = 32'hFFFFFFFF;
      for (i = 0; i < 30000 && d[2:0] !== s; i++)
         rd_reg(8'h04);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // cut a hung run short
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         fail_count++;
         stop_test();
      end
   end

   // scenarios
   initial
   begin
      {supply_pin_a, supply_pin_b, range_select, beam_clear} = 4'h8;
      {beam_marginal, optics_fault, reg_wr, reg_rd} = 4'h0;
      {bridge, select_high, mon_off, reset_n} = 4'h4;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      settle(1);
      chk_word("mode", 32'h0, {30'h0, display_mode});
      wait_st(3'h1);
      chk_word("shown time", 32'h10F, {22'h0, display_mode, display_value});
      wait_st(3'h2);
      chk_word("run", 32'h202, {22'h0, display_mode, display_value});
      rd_chk(8'h04, 32'h32, "status lock");
      rd_chk(8'h00, 32'h0, "ctrl reset");
      rd_chk(8'h0C, 32'h0, "mask reset");
      wr_reg(8'h14, 32'hFF);
      rd_chk(8'h14, 32'h0, "unmapped");
      @(posedge mclk) beam_clear <= 1'b1;
      settle(5);
      chk_word("lamps", 32'h6, {29'h0, led_yellow, led_red, safety_output_a});
      wr_reg(8'h0C, 32'h1);
      u_ric_far_side.push(100 * TK);
      settle(10);
      rd_chk(8'h04, 32'h32, "short press");
      u_ric_far_side.push(1000 * TK);
      settle(4);
      chk_word("on pins", 32'h7D, {25'h0, safety_output_a, safety_output_b,
         reset_status_pin_oe, reset_status_pin_out, led_green, led_red, irq});
      rd_chk(8'h08, 32'h1, "on event");
      wr_reg(8'h08, 32'h1);
      settle(2);
      chk_bit("irq clear", 1'b0, irq);
      settle(700);
      rd_chk(8'h04, 32'h133, "loop open");
      chk_bit("steady green", 1'b1, led_green);
      @(posedge mclk) beam_marginal <= 1'b1;
      settle(4);
      chk_word("weak", 32'h2, {30'h0, safety_output_a, reset_status_pin_oe});
      @(posedge mclk) beam_marginal <= 1'b0;
      @(posedge mclk) beam_clear <= 1'b0;
      settle(3);
      chk_word("cut", 32'h0, {29'h0, safety_output_a, safety_output_b, irq});
      rd_chk(8'h08, 32'h2, "off event");
      @(posedge mclk) beam_clear <= 1'b1;
      u_ric_far_side.push(4100 * TK);
      settle(6);
      rd_chk(8'h04, 32'h32, "held long");
      rd_chk(8'h08, 32'h6, "ignored event");
      u_ric_far_side.push(30100 * TK);
      rd_chk(8'h04, 32'h34, "stuck");
      rd_chk(8'h08, 32'hE, "stuck event");
      @(posedge mclk) reset_n <= 1'b0;
      {supply_pin_a, supply_pin_b, range_select, bridge, mon_off} <= 5'h0F;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      wait_st(3'h3);
      rd_chk(8'h04, 32'h1C3, "auto on");
      chk_word("pins", 32'h7, {29'h0, optical_channel_two,
         tx_power_standard, reset_status_pin_oe});
      wr_reg(8'h00, 32'h1);
      settle(3);
      f = display_flash;
      chk_word("align", 32'h3, {30'h0, display_mode});
      for (int k = 0; k < 510 && display_flash === f; k++)
         settle(1);
      chk_bit("blink", !f, display_flash);
      // weak reception in alignment mode blinks the green lamp
      @(posedge mclk) beam_marginal <= 1'b1;
      settle(3);
      f = led_green;
      for (int k = 0; k < 510 && led_green === f; k++)
         settle(1);
      chk_bit("green blink", !f, led_green);
      // an optics fault drops the outputs like a cut field
      @(posedge mclk) optics_fault <= 1'b1;
      settle(3);
      chk_word("optics fault", 32'h2, {30'h0, led_red, safety_output_a});
      stop_test();
   end
endmodule
`default_nettype wire
